// ---- acf_pkg.sv ----
// Package of constants and types for the conversion done flag block
package acf_pkg;
  localparam int NUM_POS = 16;
  localparam int RES_W = 12;
  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CMP_EN = 8'h08;
  localparam logic [7:0] OFS_SEQ_START = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_RESULT_BASE = 8'h40;
  localparam logic [7:0] OFS_RESULT_END = 8'h7C;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_FAST_CLR_BIT = 0;
  localparam int CTRL_CMP_IRQ_EN_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CMP_BIT = 1;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] CMP_EN_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [RES_W-1:0] RESULT_RESET = 12'h000;
  typedef enum logic [1:0] {
    ACF_IDLE = 2'b00,
    ACF_RESP = 2'b01,
    ACF_DONE = 2'b11
  } acf_wstate_t;
endpackage

// ---- acf_conv_if.sv ----
// Interface carrying conversion end events into the flag logic
`timescale 1ns/1ns
interface acf_conv_if;
  import acf_pkg::*;
  logic done;
  logic [3:0] pos;
  logic cmp_en;
  logic match;
  modport src (output done, output pos, output cmp_en, output match);
  modport dst (input done, input pos, input cmp_en, input match);
endinterface

// ---- acf_flag_bank.sv ----
// Sixteen conversion done flags with set and clear priorities
`timescale 1ns/1ns
module acf_flag_bank (
  input wire logic clk,
  input wire logic rst,
  acf_conv_if.dst conv,
  input wire logic seq_start,
  input wire logic [15:0] w1c_mask,
  input wire logic [15:0] res_rd_clr,
  input wire logic [15:0] res_wr_clr,
  output logic [15:0] conv_done_flag,
  output logic [15:0] set_vec
);
  import acf_pkg::*;
  genvar g;
  generate
    for (g = 0; g < NUM_POS; g++) begin : g_flag
      // set on done, gated by compare
      assign set_vec[g] = conv.done && (conv.pos == 4'(g)) && (!conv.cmp_en || conv.match);
      always_ff @(posedge clk) begin
        if (rst) begin
          conv_done_flag[g] <= 1'b0;
        end else if (seq_start) begin
          conv_done_flag[g] <= 1'b0;
        end else if (set_vec[g]) begin
          conv_done_flag[g] <= 1'b1;
        end else if (w1c_mask[g] || res_rd_clr[g] || res_wr_clr[g]) begin
          conv_done_flag[g] <= 1'b0;
        end
      end
    end
  endgenerate
  property p_start_clears;
    @(posedge clk) disable iff (rst) seq_start |=> (conv_done_flag == 16'h0000);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start did not clear flags");
  property p_set_wins;
    @(posedge clk) disable iff (rst) (!seq_start && set_vec[0]) |=> conv_done_flag[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag 0 set lost");
endmodule

// ---- acf_top.sv ----
// Conversion done status flags with AXI4-Lite register access
`timescale 1ns/1ns
module acf_top (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CONV_DONE,
  input wire logic [3:0] CONV_POS,
  input wire logic [acf_pkg::RES_W-1:0] CONV_RESULT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [acf_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [acf_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic [15:0] CONV_DONE_FLAG,
  output logic IRQ
);
  import acf_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic is_result(input logic [AXI_AW-1:0] a);
    return (a >= OFS_RESULT_BASE) && (a <= OFS_RESULT_END) && (a[1:0] == 2'h0);
  endfunction
  function automatic logic [3:0] result_idx(input logic [AXI_AW-1:0] a);
    return a[5:2];
  endfunction
  function automatic logic known(input logic [AXI_AW-1:0] a);
    return is_result(a) || a == OFS_STATUS || a == OFS_CTRL || a == OFS_CMP_EN
      || a == OFS_SEQ_START || a == OFS_IRQ_STATUS || a == OFS_IRQ_MASK;
  endfunction

  logic [RES_W-1:0] result_register [NUM_POS];
  logic fast_flag_clear;
  logic compare_irq_enable;
  logic [15:0] compare_enable_register;
  logic [15:0] compare_operator_select;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [15:0] flags;
  logic [15:0] set_vec;

  // ****************************************
  // Write channel
  // ****************************************
  acf_wstate_t wstate;
  logic aw_held;
  logic w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  assign wr_fire = aw_held && w_held && (wstate == ACF_IDLE);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY) && wstate == ACF_IDLE;
      S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY) && wstate == ACF_IDLE;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      wstate <= ACF_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      case (wstate)
        ACF_IDLE: begin
          if (wr_fire) begin
            wstate <= ACF_RESP;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        ACF_RESP: begin
          if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            wstate <= ACF_DONE;
          end
        end
        ACF_DONE: begin
          wstate <= ACF_IDLE;
        end
        default: begin
          wstate <= ACF_IDLE;
          S_AXI_BVALID <= 1'b0;
        end
      endcase
    end
  end

  logic lo_en;
  logic hi_en;
  assign lo_en = wr_fire && w_strb[0];
  assign hi_en = wr_fire && w_strb[1];

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      fast_flag_clear <= CTRL_RESET[CTRL_FAST_CLR_BIT];
      compare_irq_enable <= CTRL_RESET[CTRL_CMP_IRQ_EN_BIT];
    end else if (lo_en && aw_addr == OFS_CTRL) begin
      fast_flag_clear <= w_data[CTRL_FAST_CLR_BIT];
      compare_irq_enable <= w_data[CTRL_CMP_IRQ_EN_BIT];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      compare_enable_register <= CMP_EN_RESET;
      compare_operator_select <= CMP_EN_RESET;
    end else if (aw_addr == OFS_CMP_EN) begin
      if (lo_en) begin
        compare_enable_register[7:0] <= w_data[7:0];
      end
      if (hi_en) begin
        compare_enable_register[15:8] <= w_data[15:8];
      end
      if (wr_fire && w_strb[2]) begin
        compare_operator_select[7:0] <= w_data[23:16];
      end
      if (wr_fire && w_strb[3]) begin
        compare_operator_select[15:8] <= w_data[31:24];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      irq_mask <= IRQ_RESET;
    end else if (lo_en && aw_addr == OFS_IRQ_MASK) begin
      irq_mask <= w_data[1:0];
    end
  end

  // ****************************************
  // Conversion path and result registers
  // ****************************************
  logic cmp_on;
  logic cmp_true;
  assign cmp_on = compare_enable_register[CONV_POS];
  // Operator select: one means greater than, zero means less or equal
  assign cmp_true = compare_operator_select[CONV_POS] ? (CONV_RESULT > result_register[CONV_POS])
                                                      : (CONV_RESULT <= result_register[CONV_POS]);

  acf_conv_if conv_bus();
  assign conv_bus.done = CONV_DONE;
  assign conv_bus.pos = CONV_POS;
  assign conv_bus.cmp_en = cmp_on;
  assign conv_bus.match = cmp_true;

  genvar g;
  generate
    for (g = 0; g < NUM_POS; g++) begin : g_res
      always_ff @(posedge REF_CLK) begin
        if (RESET) begin
          result_register[g] <= RESULT_RESET;
        end else if (wr_fire && is_result(aw_addr) && result_idx(aw_addr) == 4'(g)
                     && compare_enable_register[g]) begin
          // Compare value writable only while compare is on
          result_register[g] <= w_data[RES_W-1:0];
        end else if (CONV_DONE && CONV_POS == 4'(g) && !compare_enable_register[g]) begin
          result_register[g] <= CONV_RESULT;
        end
      end
    end
  endgenerate

  // ****************************************
  // Flag clearing sources
  // ****************************************
  logic seq_start;
  logic [15:0] w1c_mask;
  logic [15:0] res_rd_clr;
  logic [15:0] res_wr_clr;
  logic rd_take;
  logic [AXI_AW-1:0] rd_addr;

  assign seq_start = wr_fire && aw_addr == OFS_SEQ_START;
  assign w1c_mask = (wr_fire && aw_addr == OFS_STATUS && !fast_flag_clear)
                    ? {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00} : 16'h0000;
  generate
    for (g = 0; g < NUM_POS; g++) begin : g_clr
      assign res_rd_clr[g] = rd_take && fast_flag_clear && is_result(rd_addr)
                             && result_idx(rd_addr) == 4'(g) && !compare_enable_register[g];
      assign res_wr_clr[g] = wr_fire && fast_flag_clear && is_result(aw_addr)
                             && result_idx(aw_addr) == 4'(g) && compare_enable_register[g];
    end
  endgenerate

  acf_flag_bank u_flags (
    .clk(REF_CLK),
    .rst(RESET),
    .conv(conv_bus),
    .seq_start(seq_start),
    .w1c_mask(w1c_mask),
    .res_rd_clr(res_rd_clr),
    .res_wr_clr(res_wr_clr),
    .conv_done_flag(flags),
    .set_vec(set_vec)
  );

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CONV_DONE_FLAG <= FLAGS_RESET;
    end else begin
      CONV_DONE_FLAG <= flags;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_addr = S_AXI_ARADDR;
  logic irq_rd_clr;
  assign irq_rd_clr = rd_take && rd_addr == OFS_IRQ_STATUS;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_RVALID) begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end else if (rd_take) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= known(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      if (is_result(rd_addr)) begin
        S_AXI_RDATA <= {20'h00000, result_register[result_idx(rd_addr)]};
      end else begin
        case (rd_addr)
          OFS_STATUS: S_AXI_RDATA <= {16'h0000, flags};
          OFS_CTRL: S_AXI_RDATA <= {30'h0000_0000, compare_irq_enable, fast_flag_clear};
          OFS_CMP_EN: S_AXI_RDATA <= {compare_operator_select, compare_enable_register};
          OFS_IRQ_STATUS: S_AXI_RDATA <= {30'h0000_0000, irq_status};
          OFS_IRQ_MASK: S_AXI_RDATA <= {30'h0000_0000, irq_mask};
          default: S_AXI_RDATA <= 32'h0000_0000;
        endcase
      end
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic ev_done;
  logic ev_cmp;
  assign ev_done = |set_vec && !seq_start;
  assign ev_cmp = |set_vec && cmp_on && compare_irq_enable && !seq_start;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      irq_status <= IRQ_RESET;
    end else begin
      // Set beats read clear
      irq_status[IRQ_DONE_BIT] <= ev_done || (irq_status[IRQ_DONE_BIT] && !irq_rd_clr);
      irq_status[IRQ_CMP_BIT] <= ev_cmp || (irq_status[IRQ_CMP_BIT] && !irq_rd_clr);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_cmp_event;
    CONV_DONE && cmp_on && !cmp_true;
  endsequence
  property p_cmp_false_no_set;
    @(posedge REF_CLK) disable iff (RESET) s_cmp_event |-> set_vec == 16'h0000;
  endproperty
  a_cmp_false_no_set: assert property (p_cmp_false_no_set) else $error("false compare set a flag");
  property p_result_kept;
    @(posedge REF_CLK) disable iff (RESET) (CONV_DONE && cmp_on && !wr_fire)
      |=> result_register[$past(CONV_POS)] == $past(result_register[CONV_POS]);
  endproperty
  a_result_kept: assert property (p_result_kept) else $error("compare value overwritten");
  // Covers every position, not a fixed bit that random masks may never hit
  property p_w1c;
    @(posedge REF_CLK) disable iff (RESET) (|(w1c_mask & ~set_vec))
      |=> (flags & $past(w1c_mask & ~set_vec)) == 16'h0000;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");
  property p_rd_clr;
    @(posedge REF_CLK) disable iff (RESET) (|(res_rd_clr & ~set_vec))
      |=> (flags & $past(res_rd_clr & ~set_vec)) == 16'h0000;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("result read did not clear");
  property p_wr_clr;
    @(posedge REF_CLK) disable iff (RESET) (|(res_wr_clr & ~set_vec))
      |=> (flags & $past(res_wr_clr & ~set_vec)) == 16'h0000;
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("result write did not clear");
  property p_no_load;
    @(posedge REF_CLK) disable iff (RESET) (wr_fire && aw_addr == OFS_STATUS && set_vec == 16'h0000)
      |=> (flags & ~$past(flags)) == 16'h0000;
  endproperty
  a_no_load: assert property (p_no_load) else $error("status write loaded a flag");
  property p_reset;
    @(posedge REF_CLK) RESET |=> flags == 16'h0000;
  endproperty
  a_reset: assert property (p_reset) else $error("flags not cleared by reset");
  property p_irq;
    @(posedge REF_CLK) disable iff (RESET) (ev_done && irq_mask[IRQ_DONE_BIT]) |-> ##2 IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// ---- testbench.sv ----
// Self-checking bench for the conversion done flag block
`timescale 1ns/1ns
module testbench;
  import acf_pkg::*;
  // ****************************************
  // Signals and design instance
  // ****************************************
  logic clk, rst, cd, awvalid, wvalid, bready, arvalid, rready, coin_w, coin_r, gt, pass;
  logic [3:0] cpos;
  logic [RES_W-1:0] cres, res, v;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d, seed;
  logic [15:0] expf, m;
  logic [1:0] r;
  int errors, checks_done, p, q;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] flags;
  // Coincidence drivers hold the pulse up to the edge at which the access acts
  wire conv_done = cd | (coin_w & ~bvalid) | (coin_r & arvalid);

  acf_top acf_top_i (
    .REF_CLK(clk), .RESET(rst), .CONV_DONE(conv_done), .CONV_POS(cpos), .CONV_RESULT(cres),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .CONV_DONE_FLAG(flags), .IRQ(irq)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] bitm(input int n);
    return 16'h0001 << n;
  endfunction

  function automatic logic [7:0] ra(input int n);
    return OFS_RESULT_BASE + 8'(n * 4);
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s resp %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dat;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 200);
    bready <= 1'b0;
    coin_w <= 1'b0;
    r = bresp;
    if (n >= 200) chk_val(32'h1, 32'h0, "write hang");
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 200);
    rready <= 1'b0;
    coin_r <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 200) chk_val(32'h1, 32'h0, "read hang");
  endtask

  task automatic conv(input int n, input logic [RES_W-1:0] val);
    @(posedge clk);
    cd <= 1'b1;
    cpos <= 4'(n);
    cres <= val;
    @(posedge clk);
    cd <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bound well above the expected run of under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    wrap_up();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {rst, cd, awvalid, wvalid, bready, arvalid, rready, coin_w, coin_r} = 9'h100;
    {cpos, cres, awaddr, araddr, wdata} = '0;
    seed = $urandom(32'h430b7ba5);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_val(32'(flags), 32'h0, "flag port");
    chk_val(32'(irq), 32'h0, "irq");
    rd(OFS_STATUS);
    chk_val(d, 32'h0, "status");
    $display("test reset done");
    expf = '0;
    for (int n = 0; n < 16; n++) begin
      res = RES_W'($urandom);
      conv(n, res);
      expf |= bitm(n);
      rd(ra(n));
      chk_val(d, 32'(res), "result");
      rd(OFS_STATUS);
      chk_val(d, 32'(expf), "status");
    end
    chk_val(32'(flags), 32'(expf), "flag port");
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS);
    chk_val(d, 32'hFFFF, "zero write");
    m = 16'($urandom) | 16'h0001;
    wr(OFS_STATUS, 32'(m));
    chk_resp(r, RESP_OKAY, "w1c");
    rd(OFS_STATUS);
    chk_val(d, 32'(expf & ~m), "w1c");
    wr(OFS_SEQ_START, 32'h0);
    rd(OFS_STATUS);
    chk_val(d, 32'h0, "seq start");
    $display("test set and clear done");
    p = $urandom_range(15);
    cpos <= 4'(p);
    coin_w <= 1'b1;
    wr(OFS_SEQ_START, 32'h0);
    rd(OFS_STATUS);
    chk_val(d, 32'h0, "start vs set");
    cpos <= 4'(p);
    coin_w <= 1'b1;
    wr(OFS_STATUS, 32'(bitm(p)));
    rd(OFS_STATUS);
    chk_val(d, 32'(bitm(p)), "w1c vs set");
    wr(OFS_CTRL, 32'h1);
    q = (p + 1) % 16;
    conv(q, RES_W'($urandom));
    rd(ra(q));
    rd(OFS_STATUS);
    chk_val(d, 32'(bitm(p)), "read clear");
    cpos <= 4'(q);
    coin_r <= 1'b1;
    rd(ra(q));
    rd(OFS_STATUS);
    chk_val(d, 32'(bitm(p) | bitm(q)), "read vs set");
    $display("test priority done");
    wr(OFS_SEQ_START, 32'h0);
    rd(OFS_IRQ_STATUS);
    wr(OFS_IRQ_MASK, 32'h3);
    repeat (3) @(posedge clk);
    chk_val(32'(irq), 32'h0, "irq idle");
    conv(p, RES_W'($urandom));
    repeat (4) @(posedge clk);
    chk_val(32'(irq), 32'h1, "irq raised");
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk_val(32'(irq), 32'h0, "irq masked");
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_SEQ_START, 32'h0);
    rd(OFS_IRQ_STATUS);
    chk_val(d & 32'h1, 32'h1, "irq status");
    repeat (3) @(posedge clk);
    chk_val(32'(irq), 32'h0, "irq cleared");
    $display("test interrupt done");
    for (int t = 0; t < 6; t++) begin
      p = $urandom_range(15);
      // Last round runs with the compare interrupt disabled
      wr(OFS_CTRL, (t == 5) ? 32'h1 : 32'h3);
      gt = t[0];
      v = RES_W'($urandom);
      res = (t < 2) ? v : RES_W'($urandom);
      pass = gt ? (res > v) : (res <= v);
      wr(OFS_CMP_EN, (32'(gt) << (16 + p)) | 32'(bitm(p)));
      wr(ra(p), 32'(v));
      wr(OFS_SEQ_START, 32'h0);
      rd(OFS_IRQ_STATUS);
      conv(p, res);
      rd(OFS_STATUS);
      chk_val(d & 32'(bitm(p)), pass ? 32'(bitm(p)) : 32'h0, "compare flag");
      rd(OFS_IRQ_STATUS);
      chk_val(32'(d[IRQ_CMP_BIT]), 32'(pass && t != 5), "compare irq");
      rd(ra(p));
      chk_val(d, 32'(v), "compare value kept");
      wr(ra(p), 32'(v));
      rd(OFS_STATUS);
      chk_val(d & 32'(bitm(p)), 32'h0, "write clear");
    end
    $display("test compare done");
    rd(8'h30);
    chk_resp(r, RESP_SLVERR, "unmapped read");
    chk_val(d, 32'h0, "unmapped data");
    wr(8'h30, 32'hFFFFFFFF);
    chk_resp(r, RESP_SLVERR, "unmapped write");
    $display("test unmapped done");
    wrap_up();
  end
endmodule
